/* File: rtl/csdc_defines.vh */
// constants for the clock switch and doze control block
// assumes a 16-bit register port with byte strobes folded into writes
`ifndef CSDC_DEFINES_VH
`define CSDC_DEFINES_VH

// register addresses
`define CSDC_ADDR_OSC_CTRL   2'h0
`define CSDC_ADDR_OSC_CTRL_H 2'h1
`define CSDC_ADDR_CLK_DIV    2'h2
`define CSDC_ADDR_RC_TUNE    2'h3

// unlock key values
`define CSDC_KEY_HI_1        8'h78
`define CSDC_KEY_HI_2        8'h9a
`define CSDC_KEY_LO_1        8'h46
`define CSDC_KEY_LO_2        8'h57

// oscillator_control field positions
`define CSDC_BIT_SWREQ       0
`define CSDC_BIT_SECONDARY_OSCILLATOR_EN     1
`define CSDC_BIT_SECONDARY_OSCILLATOR_DRV    2
`define CSDC_BIT_FAIL        3
`define CSDC_BIT_PLL_LOCK    5
`define CSDC_BIT_SEL_LOCK    7

// clock_divider field positions and reset values
`define CSDC_BIT_ROI         15
`define CSDC_BIT_DOZE_EN     11
`define CSDC_DOZE_RESET      3'h3
`define CSDC_RC_POSTSCALER_RESET     3'h1

// write data field bounds
`define CSDC_KEY_MSB         7
`define CSDC_NEW_SOURCE_MSB        10
`define CSDC_NEW_SOURCE_LSB        8
`define CSDC_DOZE_MSB        14
`define CSDC_DOZE_LSB        12
`define CSDC_RC_POSTSCALER_MSB       10
`define CSDC_RC_POSTSCALER_LSB       8
`define CSDC_TUNE_MSB        5

// source codes
`define CSDC_SRC_FRC         3'h0
`define CSDC_SRC_FRCPLL      3'h1
`define CSDC_SRC_PRI         3'h2
`define CSDC_SRC_PRIPLL      3'h3
`define CSDC_SRC_SEC         3'h4
`define CSDC_SRC_LOW_POWER_RC_OSCILLATOR        3'h5
`define CSDC_SRC_LPFRCDIV    3'h6
`define CSDC_SRC_FRCDIV      3'h7

// timing: settle cycles of the new clock before changeover
`define CSDC_SETTLE_CYCLES   4'ha

`endif

/* File: rtl/csdc_clock_switch.v */
// clock switch, doze divider and rc tuning control registers
// assumes one 10 MHz clock; oscillator readiness arrives as levels
// Function
// (RQ1) lock bit freezes selections when monitor enabled
// (RQ2) pll lock reads locked or timer satisfied
// (RQ3) pll lock cleared on switch start, non-pll mode
// (RQ4) fail flag hardware set, software clear only
// (RQ5) drive bit selects high-power secondary circuit
// (RQ6) enable bit turns secondary oscillator on
// (RQ7) request bit starts switch, cleared when done
// (RQ8) recover bit: interrupt clears doze enable
// (RQ9) doze ratio 1:2^n, reset code 011
// (RQ10) doze enable gates ratio, else 1:1
// (RQ11) postscaler divides fast rc, code 111 /256
// (RQ12) same postscaler applies to low-power fast rc
// (RQ13) tuning field is signed six-bit offset
// (RQ14) switching disabled unless enable fuse is 0
// (RQ15) disabled switching: request reads 0, fuse source
// (RQ16) high byte unlock 78h then 9Ah
// (RQ17) low byte unlock 46h then 57h
// (RQ18) equal sources abandon switch, clear request
// (RQ19) valid switch clears flags, starts, waits ready
// (RQ20) wait ten new-clock cycles before changeover
// (RQ21) completion copies source, stops old source
// (RQ22) software avoids direct pll to pll switch
// (RQ23) three-bit source code table
// (RQ24) unlock covers only the next single write
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "csdc_defines.vh"

module csdc_clock_switch
#(
	parameter SRC_W = 3              // source code width
)
(
	input  wire             i_clk_sys,      // 10 MHz system clock
	input  wire             i_rst,          // sync reset, active high
	input  wire [1:0]       i_addr,         // register address
	input  wire [15:0]      i_wdata,        // write data
	input  wire             i_wr,           // write strobe
	input  wire             i_rd,           // read strobe
	output reg  [15:0]      o_rdata,        // read data, next cycle
	input  wire             i_switch_enable_fuse,   // 0 enables switching
	input  wire             i_failsafe_monitor_fuse,// 0 enables monitor
	input  wire [SRC_W-1:0] i_initial_source_fuse,  // reset source
	input  wire             i_secondary_source_fuse,// 0 digital input
	input  wire             i_osc_ready,    // new source startup done
	input  wire             i_pll_locked,   // pll lock or timer met
	input  wire             i_new_clk_tick, // one pulse per new clock
	input  wire             i_clock_fail,   // monitor failure pulse
	input  wire             i_interrupt,    // any interrupt pulse
	input  wire             i_low_power_rc_oscillator_keep,    // wdt/monitor/rtc use low_power_rc_oscillator
	output reg  [SRC_W-1:0] o_system_source,// active clock source
	output reg  [SRC_W-1:0] o_start_source, // source being started
	output reg              o_start_valid,  // start source enable
	output reg  [7:0]       o_sources_on,   // one bit per source
	output reg              o_secondary_high_power, // high drive
	output reg  [2:0]       o_doze_ratio,   // log2 cpu:periph ratio
	output reg  [2:0]       o_rc_postscaler,// applied postscaler code
	output reg  [8:0]       o_rc_divide,    // applied divisor
	output reg  [5:0]       o_tune_offset   // signed rc trim
);

	localparam ST_IDLE   = 2'h0;
	localparam ST_READY  = 2'h1;
	localparam ST_SETTLE = 2'h2;

	// divisor table: 1..64 by powers of two, 111 is 256
	// a plain shift would give 128 at the top code, so it is special
	function [8:0] rc_div;
		input [2:0] code;
		begin
			if (code == 3'h7)
				rc_div = 9'h100;
			else
				rc_div = 9'h001 << code;
		end
	endfunction

	// does this source run through the pll
	function uses_pll;
		input [2:0] src;
		begin
			uses_pll = (src == `CSDC_SRC_FRCPLL) || // see (RQ23)
				(src == `CSDC_SRC_PRIPLL);
		end
	endfunction

	reg [SRC_W-1:0] current_source;
	reg [SRC_W-1:0] new_source;
	reg             switch_request;
	reg             selection_lock;
	reg             pll_lock;
	reg             clock_fail_flag;
	reg             secondary_drive_select;
	reg             secondary_osc_enable;
	reg             recover_on_interrupt;
	reg [2:0]       doze_ratio;
	reg             doze_enable;
	reg [2:0]       rc_postscaler;
	reg [5:0]       tune_offset;
	reg [1:0]       hi_key;         // 2 = armed for one write
	reg [1:0]       lo_key;
	reg [1:0]       state;
	reg [3:0]       settle_cnt;
	reg             strap_done;
	reg [7:0]       next_sources_on; // sources to keep running

	// one fuse off disables both switching and the monitor
	wire sw_en      = ~i_switch_enable_fuse;                   // see (RQ14)
	wire mon_en     = sw_en & ~i_failsafe_monitor_fuse;
	wire sel_frozen = mon_en & selection_lock;                  // see (RQ1)
	wire wr_lo      = i_wr && (i_addr == `CSDC_ADDR_OSC_CTRL);
	wire wr_hi      = i_wr && (i_addr == `CSDC_ADDR_OSC_CTRL_H);
	wire wr_lo_ok   = wr_lo && (lo_key == 2'h2);                // see (RQ24)
	wire wr_hi_ok   = wr_hi && (hi_key == 2'h2);
	wire req_set    = wr_lo_ok && i_wdata[`CSDC_BIT_SWREQ] &&
		sw_en && !sel_frozen && !switch_request;                 // see (RQ15)

	// write data fields, so the bit map lives in the header
	wire [7:0]       wd_key    = i_wdata[`CSDC_KEY_MSB:0];
	wire [SRC_W-1:0] wd_source = i_wdata[`CSDC_NEW_SOURCE_MSB:`CSDC_NEW_SOURCE_LSB];
	wire [2:0]       wd_doze   = i_wdata[`CSDC_DOZE_MSB:`CSDC_DOZE_LSB];
	wire [2:0]       wd_rc_postscaler  = i_wdata[`CSDC_RC_POSTSCALER_MSB:`CSDC_RC_POSTSCALER_LSB];
	wire [5:0]       wd_tune   = i_wdata[`CSDC_TUNE_MSB:0];

	// unlock tracking; any other register write breaks a sequence
	// reads leave the keys alone, so software may poll between them
	always @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			hi_key <= 2'h0;
			lo_key <= 2'h0;
		end
		else if (i_wr)
		begin
			if (wr_hi && hi_key == 2'h0 &&
				wd_key == `CSDC_KEY_HI_1)
				hi_key <= 2'h1;                                   // see (RQ16)
			else if (wr_hi && hi_key == 2'h1 &&
				wd_key == `CSDC_KEY_HI_2)
				hi_key <= 2'h2;
			else
				hi_key <= 2'h0;                                   // see (RQ24)
			if (wr_lo && lo_key == 2'h0 &&
				wd_key == `CSDC_KEY_LO_1)
				lo_key <= 2'h1;                                   // see (RQ17)
			else if (wr_lo && lo_key == 2'h1 &&
				wd_key == `CSDC_KEY_LO_2)
				lo_key <= 2'h2;
			else
				lo_key <= 2'h0;
		end
	end

	// switch engine and oscillator_control state
	always @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			// default source until the fuse straps are caught
			current_source         <= `CSDC_SRC_FRCDIV;
			new_source             <= `CSDC_SRC_FRCDIV;
			strap_done             <= 1'b0;
			switch_request         <= 1'b0;
			selection_lock         <= 1'b0;
			pll_lock               <= 1'b0;
			clock_fail_flag        <= 1'b0;
			secondary_drive_select <= 1'b0;
			secondary_osc_enable   <= 1'b0;
			state                  <= ST_IDLE;
			settle_cnt             <= 4'h0;
		end
		else
		begin
			// fuse straps are caught after reset release
			if (!strap_done)
			begin
				strap_done     <= 1'b1;
				current_source <= i_initial_source_fuse;
				new_source     <= i_initial_source_fuse;
			end
			if (!sw_en)
				current_source <= i_initial_source_fuse;          // see (RQ15)
			// retargeting mid-switch would start one source and hand
			// over to another, so the field is held while a switch runs
			if (wr_hi_ok && sw_en && !sel_frozen && strap_done &&
				state == ST_IDLE)
				new_source <= wd_source;                          // see (RQ16)
			if (wr_lo_ok)
			begin
				secondary_drive_select <= i_wdata[`CSDC_BIT_SECONDARY_OSCILLATOR_DRV];
				secondary_osc_enable   <= i_wdata[`CSDC_BIT_SECONDARY_OSCILLATOR_EN];
				// lock is settable only
				if (i_wdata[`CSDC_BIT_SEL_LOCK])
					selection_lock <= 1'b1;
				// flag clearable only
				if (!i_wdata[`CSDC_BIT_FAIL])
					clock_fail_flag <= 1'b0;                      // see (RQ4)
			end
			// pll status follows the pll in pll modes only
			if (!uses_pll(current_source))
				pll_lock <= 1'b0;                                 // see (RQ3)
			else if (state == ST_IDLE)
				pll_lock <= i_pll_locked;                         // see (RQ2)
			case (state)
				ST_IDLE:
				begin
					if (req_set && strap_done)
					begin
						switch_request <= 1'b1;                   // see (RQ7)
						if (new_source == current_source)
							switch_request <= 1'b0;               // see (RQ18)
						else
						begin
							pll_lock        <= 1'b0;              // see (RQ19)
							clock_fail_flag <= 1'b0;
							state           <= ST_READY;
						end
					end
				end
				ST_READY:
				begin
					// wait on startup timer and pll lock
					if (uses_pll(new_source))
						pll_lock <= i_pll_locked;
					if (i_osc_ready &&
						(!uses_pll(new_source) || i_pll_locked))
					begin
						settle_cnt <= 4'h0;
						state      <= ST_SETTLE;
					end
				end
				ST_SETTLE:
				begin
					// the tenth tick, taken at count nine, is the changeover
					if (i_new_clk_tick)
						settle_cnt <= settle_cnt + 4'h1;          // see (RQ20)
					if (i_new_clk_tick &&
						settle_cnt == `CSDC_SETTLE_CYCLES - 4'h1)
					begin
						current_source <= new_source;             // see (RQ21)
						switch_request <= 1'b0;                   // see (RQ7)
						state          <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
			// set wins over a same-cycle software clear
			if (i_clock_fail && mon_en)
				clock_fail_flag <= 1'b1;                          // see (RQ4)
		end
	end

	// clock_divider and rc_tune; interrupt recovery beats writes
	always @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			recover_on_interrupt <= 1'b0;
			doze_ratio           <= `CSDC_DOZE_RESET;              // see (RQ9)
			doze_enable          <= 1'b0;
			rc_postscaler        <= `CSDC_RC_POSTSCALER_RESET;             // see (RQ11)
			tune_offset          <= 6'h00;
		end
		else
		begin
			// the ratio code is kept while doze is off, applies once enabled
			if (i_wr && i_addr == `CSDC_ADDR_CLK_DIV)
			begin
				recover_on_interrupt <= i_wdata[`CSDC_BIT_ROI];
				doze_ratio           <= wd_doze;
				doze_enable          <= i_wdata[`CSDC_BIT_DOZE_EN];
				rc_postscaler        <= wd_rc_postscaler;
			end
			if (i_wr && i_addr == `CSDC_ADDR_RC_TUNE)
				tune_offset <= wd_tune;                           // see (RQ13)
			if (i_interrupt && recover_on_interrupt)
				doze_enable <= 1'b0;                              // see (RQ8)
		end
	end

	// only the active source, a starting one and kept ones run; the old
	// source drops out on the changeover edge unless something uses it
	always @*
	begin
		next_sources_on = 8'h01 << current_source;
		if (state != ST_IDLE)
			next_sources_on = next_sources_on | (8'h01 << new_source);
		if (i_low_power_rc_oscillator_keep)
			next_sources_on = next_sources_on |
				(8'h01 << `CSDC_SRC_LOW_POWER_RC_OSCILLATOR);                        // see (RQ21)
		if (secondary_osc_enable)
			next_sources_on = next_sources_on |
				(8'h01 << `CSDC_SRC_SEC);                         // see (RQ6)
	end

	// outputs toward the oscillators and dividers
	always @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_system_source        <= `CSDC_SRC_FRCDIV;
			o_start_source         <= `CSDC_SRC_FRCDIV;
			o_start_valid          <= 1'b0;
			o_sources_on           <= 8'h00;
			o_secondary_high_power <= 1'b0;
			o_doze_ratio           <= 3'h0;
			o_rc_postscaler        <= 3'h0;
			o_rc_divide            <= 9'h001;
			o_tune_offset          <= 6'h00;
		end
		else
		begin
			o_system_source <= current_source;
			o_start_source  <= new_source;
			o_start_valid   <= (state != ST_IDLE);                // see (RQ19)
			o_sources_on    <= next_sources_on;                   // see (RQ21)
			// drive bit is moot with a digital secondary input
			o_secondary_high_power <= secondary_drive_select &
				i_secondary_source_fuse;                          // see (RQ5)
			o_doze_ratio    <= doze_enable ? doze_ratio : 3'h0;   // see (RQ10)
			if (current_source == `CSDC_SRC_FRCDIV ||
				current_source == `CSDC_SRC_LPFRCDIV)
			begin
				o_rc_postscaler <= rc_postscaler;                 // see (RQ12)
				o_rc_divide     <= rc_div(rc_postscaler);         // see (RQ11)
			end
			else
			begin
				// other sources see code 0, leaving the divider at 1
				o_rc_postscaler <= 3'h0;
				o_rc_divide     <= 9'h001;
			end
			o_tune_offset   <= tune_offset;
		end
	end

	// read data, one cycle after the strobe; reserved bits zero
	// both byte addresses return the whole register
	always @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_rdata <= 16'h0000;
		else if (i_rd)
		begin
			case (i_addr)
				`CSDC_ADDR_OSC_CTRL, `CSDC_ADDR_OSC_CTRL_H:
					o_rdata <= {1'b0, current_source, 1'b0,
						new_source, selection_lock, 1'b0, pll_lock,
						1'b0, clock_fail_flag, secondary_drive_select,
						secondary_osc_enable,
						switch_request & sw_en};                  // see (RQ15)
				`CSDC_ADDR_CLK_DIV:
					o_rdata <= {recover_on_interrupt, doze_ratio,
						doze_enable, rc_postscaler, 8'h00};
				`CSDC_ADDR_RC_TUNE:
					o_rdata <= {10'h000, tune_offset};
				default:
					o_rdata <= 16'h0000;
			endcase
		end
		else
			o_rdata <= 16'h0000;
	end

endmodule // csdc_clock_switch

`default_nettype wire

/* File: sim/csdc_clock_switch_chk.sv */
// assertion checker for the clock switch block
// assumes it is bound to csdc_clock_switch and sees its ports only
`timescale 1ns/1ns
`default_nettype none

module csdc_clock_switch_chk
#(
	parameter SRC_W = 3                    // source code width
)
(
	input wire logic             i_clk_sys,       // system clock
	input wire logic             i_rst,           // sync reset
	input wire logic             i_switch_enable_fuse, // 0 enables
	input wire logic             i_new_clk_tick,  // new clock pulse
	input wire logic [SRC_W-1:0] o_system_source, // active source
	input wire logic [SRC_W-1:0] o_start_source,  // source started
	input wire logic             o_start_valid,   // switch busy
	input wire logic [7:0]       o_sources_on,    // running sources
	input wire logic [2:0]       o_rc_postscaler, // applied code
	input wire logic [8:0]       o_rc_divide      // applied divisor
);
	logic [7:0] tick_cnt;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// ticks seen while busy; saturates so a stuck switch never wraps
	always @(posedge i_clk_sys)
	begin
		if (i_rst || !o_start_valid)
			tick_cnt <= 8'h00;
		else if (i_new_clk_tick && tick_cnt != 8'hff)
			tick_cnt <= tick_cnt + 8'h01;
	end

	// divisor follows the postscaler table, top code jumps to 256
	AST_DIV_TABLE: assert property (o_rc_divide == ((o_rc_postscaler == 3'h7) ?
		9'h100 : (9'h001 << o_rc_postscaler)))
		else $error("divisor does not match postscaler code");
	AST_POST_SRC: assert property (o_rc_postscaler != 3'h0 |->
		(o_system_source == 3'h7 || o_system_source == 3'h6))
		else $error("postscaler applied to a non rc source");
	AST_FUSE_OFF: assert property (i_switch_enable_fuse &&
		$past(i_switch_enable_fuse) |-> !o_start_valid)
		else $error("switch started while switching disabled");
	// source loads from fuses on the second edge after reset, seen by the check on the third
	AST_ONLY_SWITCH: assert property ($changed(o_system_source) &&
		!$past(i_rst, 3) |-> $past(o_start_valid))
		else $error("source changed outside a switch");
	AST_TEN_TICKS: assert property ($changed(o_system_source) &&
		!$past(i_rst, 3) |-> tick_cnt >= 8'h0a)
		else $error("changeover before ten new clock cycles");
	AST_BUSY_DIFF: assert property (o_start_valid |->
		o_start_source != o_system_source)
		else $error("switch in progress to the same source");
	AST_DONE_COPY: assert property ($fell(o_start_valid) |->
		o_system_source == o_start_source)
		else $error("completed switch did not copy new source");
	AST_ACTIVE_ON: assert property (!$past(i_rst, 4) |->
		o_sources_on[o_system_source])
		else $error("active source is not running");
	AST_START_ON: assert property ($rose(o_start_valid) |->
		##[0:2] o_sources_on[o_start_source])
		else $error("new source not enabled at switch start");
endmodule // csdc_clock_switch_chk

`default_nettype wire

/* File: sim/test_csdc_clock_switch.sv */
// self-checking bench for the clock switch and doze control block
// assumes the register port contract: read data in the cycle after i_rd
`timescale 1ns/1ns
`default_nettype none

module test_csdc_clock_switch;
	logic        i_clk_sys = 1'b0;
	logic        i_rst = 1'b1;
	logic [1:0]  i_addr = 2'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_switch_enable_fuse = 1'b0;
	logic        i_failsafe_monitor_fuse = 1'b0;
	logic [2:0]  i_initial_source_fuse = 3'h7;
	logic        i_secondary_source_fuse = 1'b1;
	logic        i_osc_ready = 1'b0;
	logic        i_pll_locked = 1'b0;
	logic        i_new_clk_tick = 1'b0;
	logic        i_clock_fail = 1'b0;
	logic        i_interrupt = 1'b0;
	logic        i_low_power_rc_oscillator_keep = 1'b0;
	logic [15:0] o_rdata;
	logic [2:0]  o_system_source;
	logic [2:0]  o_start_source;
	logic        o_start_valid;
	logic [7:0]  o_sources_on;
	logic        o_secondary_high_power;
	logic [2:0]  o_doze_ratio;
	logic [2:0]  o_rc_postscaler;
	logic [8:0]  o_rc_divide;
	logic [5:0]  o_tune_offset;
	int          errors = 0;
	int          n_compared = 0;

	csdc_clock_switch i_csdc_clock_switch
	(
		.i_clk_sys               (i_clk_sys),
		.i_rst                   (i_rst),
		.i_addr                  (i_addr),
		.i_wdata                 (i_wdata),
		.i_wr                    (i_wr),
		.i_rd                    (i_rd),
		.o_rdata                 (o_rdata),
		.i_switch_enable_fuse    (i_switch_enable_fuse),
		.i_failsafe_monitor_fuse (i_failsafe_monitor_fuse),
		.i_initial_source_fuse   (i_initial_source_fuse),
		.i_secondary_source_fuse (i_secondary_source_fuse),
		.i_osc_ready             (i_osc_ready),
		.i_pll_locked            (i_pll_locked),
		.i_new_clk_tick          (i_new_clk_tick),
		.i_clock_fail            (i_clock_fail),
		.i_interrupt             (i_interrupt),
		.i_low_power_rc_oscillator_keep             (i_low_power_rc_oscillator_keep),
		.o_system_source         (o_system_source),
		.o_start_source          (o_start_source),
		.o_start_valid           (o_start_valid),
		.o_sources_on            (o_sources_on),
		.o_secondary_high_power  (o_secondary_high_power),
		.o_doze_ratio            (o_doze_ratio),
		.o_rc_postscaler         (o_rc_postscaler),
		.o_rc_divide             (o_rc_divide),
		.o_tune_offset           (o_tune_offset)
	);

	// 10 MHz system clock
	always #50 i_clk_sys = ~i_clk_sys;

	task end_of_test;
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// write strobe stays up so key writes stay back to back
	task wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
	endtask

	task idle;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
	endtask

	// data is looked at only in the cycle after the strobe
	task rd_raw(input logic [1:0] a, output logic [15:0] v);
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask

	task rd(input logic [1:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd_raw(a, v);
		chk(v, exp);
	endtask

	// key pair then one data write, for either byte
	task hi(input logic [2:0] src);
		wr(2'h1, 16'h0078);
		wr(2'h1, 16'h009a);
		wr(2'h1, {5'h00, src, 8'h00});
		idle;
	endtask

	task lo(input logic [7:0] v);
		wr(2'h0, 16'h0046);
		wr(2'h0, 16'h0057);
		wr(2'h0, {8'h00, v});
		idle;
	endtask

	task tick(input int n);
		repeat (n)
		begin
			@(posedge i_clk_sys) i_new_clk_tick <= 1'b1;
			@(posedge i_clk_sys) i_new_clk_tick <= 1'b0;
		end
	endtask

	// polls the request bit; a hang counts as a mismatch
	task wait_clear;
		int k;
		logic [15:0] v;
		k = 0;
		rd_raw(2'h0, v);
		while (v[0] !== 1'b0 && k < 50)
		begin
			rd_raw(2'h0, v);
			k++;
		end
		if (v[0] !== 1'b0)
		begin
			chk({15'h0, v[0]}, 16'h0000);
			end_of_test;
		end
	endtask

	task reset_dut(input logic fuse, input logic [2:0] src);
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		i_switch_enable_fuse <= fuse;
		i_initial_source_fuse <= src;
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
	endtask

	// main sequence
	initial
	begin
		reset_dut(1'b0, 3'h7);
		rd(2'h0, 16'h7700);
		rd(2'h2, 16'h3100);
		chk(o_rc_divide, 9'h002);
		wr(2'h3, 16'hffe0);
		idle;
		rd(2'h3, 16'h0020);
		chk(o_tune_offset, 6'h20);
		wr(2'h1, 16'h0300);
		wr(2'h1, 16'h0078);
		wr(2'h1, 16'h0300);
		idle;
		rd(2'h0, 16'h7700);
		wr(2'h2, 16'hff00);
		idle;
		rd(2'h2, 16'hff00);
		chk(o_doze_ratio, 3'h7);
		chk(o_rc_divide, 9'h100);
		@(posedge i_clk_sys) i_interrupt <= 1'b1;
		@(posedge i_clk_sys) i_interrupt <= 1'b0;
		rd(2'h2, 16'hf700);
		chk(o_doze_ratio, 3'h0);
		hi(3'h7);
		lo(8'h01);
		wait_clear;
		rd(2'h0, 16'h7700);
		hi(3'h0);
		lo(8'h01);
		rd(2'h0, 16'h7001);
		@(posedge i_clk_sys) i_osc_ready <= 1'b1;
		tick(9);
		rd(2'h0, 16'h7001);
		tick(1);
		wait_clear;
		rd(2'h0, 16'h0000);
		chk(o_sources_on[7], 1'b0);
		chk(o_rc_postscaler, 3'h0);
		hi(3'h1);
		lo(8'h01);
		tick(12);
		rd(2'h0, 16'h0101);
		@(posedge i_clk_sys) i_pll_locked <= 1'b1;
		tick(10);
		wait_clear;
		rd(2'h0, 16'h1120);
		hi(3'h0);
		lo(8'h01);
		tick(10);
		wait_clear;
		rd(2'h0, 16'h0000);
		@(posedge i_clk_sys) i_clock_fail <= 1'b1;
		@(posedge i_clk_sys) i_clock_fail <= 1'b0;
		rd(2'h0, 16'h0008);
		lo(8'h00);
		lo(8'h08);
		rd(2'h0, 16'h0000);
		lo(8'h06);
		rd(2'h0, 16'h0006);
		chk(o_secondary_high_power, 1'b1);
		chk(o_sources_on[4], 1'b1);
		hi(3'h6);
		lo(8'h01);
		tick(10);
		wait_clear;
		chk(o_rc_divide, 9'h100);
		chk(o_rc_postscaler, 3'h7);
		chk(o_sources_on[0], 1'b0);
		lo(8'h80);
		@(posedge i_clk_sys) i_low_power_rc_oscillator_keep <= 1'b1;
		hi(3'h0);
		lo(8'h01);
		rd(2'h0, 16'h6680);
		chk(o_sources_on[5], 1'b1);
		reset_dut(1'b1, 3'h5);
		hi(3'h0);
		lo(8'h01);
		rd(2'h0, 16'h5500);
		chk(o_system_source, 3'h5);
		end_of_test;
	end
endmodule // test_csdc_clock_switch

bind csdc_clock_switch csdc_clock_switch_chk #(.SRC_W(SRC_W)) u_chk
(
	.i_clk_sys            (i_clk_sys),
	.i_rst                (i_rst),
	.i_switch_enable_fuse (i_switch_enable_fuse),
	.i_new_clk_tick       (i_new_clk_tick),
	.o_system_source      (o_system_source),
	.o_start_source       (o_start_source),
	.o_start_valid        (o_start_valid),
	.o_sources_on         (o_sources_on),
	.o_rc_postscaler      (o_rc_postscaler),
	.o_rc_divide          (o_rc_divide)
);

`default_nettype wire
